// >>> core/tmioc_pkg.sv
/*
  Constants, register map and slot table of the timer mode and I/O control
  block. Assumes a 32-bit AXI4-Lite register bus and six timer channels.
*/
package tmioc_pkg;

  // Sizes
  localparam int NCH   = 6;
  localparam int NSLOT = 16;
  localparam int CW    = 16;
  localparam int NIO   = 8;

  // Register word indices, byte address is four times the index
  localparam logic [5:0] IDX_IOAB    = 6'h00;
  localparam logic [5:0] IDX_IOCD0   = 6'h06;
  localparam logic [5:0] IDX_IOCD3   = 6'h07;
  localparam logic [5:0] IDX_MODE    = 6'h08;
  localparam logic [5:0] IDX_START   = 6'h0e;
  localparam logic [5:0] IDX_CLKSEL  = 6'h0f;
  localparam logic [5:0] IDX_PINSTAT = 6'h10;
  localparam logic [5:0] IDX_GREG    = 6'h20;

  // I/O control nibble fields
  localparam int CTL_MODE_BIT = 3;
  localparam int CTL_INIT_BIT = 2;
  localparam int CTL_SRC_BIT  = 2;

  // Channel mode register fields
  localparam int MODE_BUFB_BIT  = 5;
  localparam int MODE_BUFA_BIT  = 4;
  localparam int MODE_RSVD_BIT  = 3;
  localparam int MODE_PHASE_BIT = 2;

  // Reset values
  localparam logic [7:0]  IOCTL_RST    = 8'h00;
  localparam logic [5:0]  MODE_RST     = 6'h00;
  localparam logic [7:0]  MODE_RD_ONES = 8'hc0;
  localparam logic [5:0]  START_RST    = 6'h00;
  localparam logic [2:0]  CLKSEL_RST   = 3'h0;
  localparam logic [15:0] GREG_RST     = 16'h0000;

  // Mode encodings
  localparam logic [3:0] MD_NORMAL = 4'h0;
  localparam logic [3:0] MD_PWM1   = 4'h2;
  localparam logic [3:0] MD_PWM2   = 4'h3;
  localparam logic [1:0] MD_PHASE  = 2'h1;

  // Output compare and capture edge encodings
  localparam logic [1:0] OUT_DISABLED = 2'h0;
  localparam logic [1:0] OUT_LOW      = 2'h1;
  localparam logic [1:0] OUT_HIGH     = 2'h2;
  localparam logic [1:0] OUT_TOGGLE   = 2'h3;
  localparam logic [1:0] CAP_RISE     = 2'h0;
  localparam logic [1:0] CAP_FALL     = 2'h1;

  // Channel 1 clock select giving the undivided clock
  localparam logic [2:0] CLKSEL_UNDIV = 3'h0;

  // Channel capabilities
  localparam logic [NCH-1:0] PHASE_OK = 6'h36;
  localparam logic [NCH-1:0] HAS_CD   = 6'h09;

  // Slot table: ch0 A B C D, ch1 A B, ch2 A B, ch3 A B C D, ch4 A B, ch5 A B
  localparam int SLOT_CHAN  [NSLOT] =
    '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 3, 4, 4, 5, 5};
  localparam int SLOT_IOREG [NSLOT] =
    '{0, 0, 6, 6, 1, 1, 2, 2, 3, 3, 7, 7, 4, 4, 5, 5};
  localparam logic [NSLOT-1:0] SLOT_HI = 16'haaaa;
  localparam logic [NSLOT-1:0] SLOT_CD = 16'h0c0c;
  localparam int SLOT_CH1_SRC = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> core/tmioc_greg_mem.sv
/*
  General register store: one word per slot, each loaded on its own
  write enable, with a registered read port and all words exposed.
  Assumes the caller resolves priority between writers per entry.
*/
module tmioc_greg_mem
  import tmioc_pkg::*;
#(
  parameter int N = 16,
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Write side
  input  wire logic [N-1:0]         we,
  input  wire logic [N*W-1:0]       wdata,
  // Read side
  input  wire logic [$clog2(N)-1:0] rd_addr,
  output logic      [W-1:0]         rd_q,
  output logic      [N*W-1:0]       all_q
);

  logic [W-1:0] word_q [N];

  for (genvar i = 0; i < N; i++) begin : g_word
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        word_q[i] <= W'(GREG_RST);
      end else if (we[i]) begin
        word_q[i] <= wdata[i*W +: W];
      end
    end
    assign all_q[i*W +: W] = word_q[i];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else begin
      rd_q <= word_q[rd_addr];
    end
  end

endmodule

// >>> core/tmioc_top.sv
/*
  Mode selection and general-register I/O control of a six-channel timer,
  with an AXI4-Lite register slave. Assumes counters, prescalers and the
  count events live outside and arrive synchronous to mclk.
*/
// Overview of operation
// - Mode field 0000 normal, 0010/0011 PWM 1/2, 0100-0111 phase 1-4.
// - Channels 0 and 3 have no phase counting; their mode bit 2 is zero.
// - Eight I/O control registers: two each for channels 0, 3, one others.
// - Initial output level is driven while the channel is stopped.
// - In PWM mode 2 the initial level is driven on counter clear.
// - Buffered register C or D ignores its I/O control setting.
// - Main control: bits 7-4 set register B, 3-0 register A; reset zero.
// - Low control of channels 0, 3: bits 7-4 register D, 3-0 register C.
// - Bit 3 zero: compare; bit 2 initial level; 1:0 off, 0, 1, toggle.
// - Bit 3 one: capture on rising, falling or both edges.
// - Channel 0 register B bit 2 picks pin or channel 1 count events.
// - Channel 1 clock select 000 blocks channel 1 sourced capture.
// - A buffered register D makes neither capture nor compare.
module tmioc_top
  import tmioc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // AXI4-Lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Counter side
  input  wire logic [NCH*CW-1:0] cnt_value,
  input  wire logic [NCH-1:0]    cnt_clear,
  input  wire logic              ch1_count_evt,
  output logic [NCH-1:0]         counter_start,
  output logic [2:0]             ch1_clock_select,
  // Mode decode
  output logic [NCH-1:0]         mode_pwm1,
  output logic [NCH-1:0]         mode_pwm2,
  output logic [NCH-1:0]         mode_phase,
  output logic [2*NCH-1:0]       phase_kind,
  output logic [NCH-1:0]         buffer_a,
  output logic [NCH-1:0]         buffer_b,
  // Timer pins, one per general register
  input  wire logic [NSLOT-1:0]  cap_pin_in,
  output logic [NSLOT-1:0]       pin_out,
  output logic [NSLOT-1:0]       pin_oe_n,
  // Events
  output logic [NSLOT-1:0]       cmp_match,
  output logic [NSLOT-1:0]       capture_evt
);

  // Register state
  logic [7:0]       io_q [NIO];
  logic [5:0]       mode_q [NCH];
  logic [NCH-1:0]   start_q;
  logic [2:0]       clksel_q;

  // Bus state
  logic             aw_have_q;
  logic             w_have_q;
  logic [5:0]       wr_word_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rd_stage_q;
  logic [5:0]       rd_word_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  // Slot state
  logic [NSLOT-1:0] pin_q;
  logic [NSLOT-1:0] oe_n_q;
  logic [NSLOT-1:0] eq_q;
  logic [NSLOT-1:0] pin_in_q;
  logic [NSLOT-1:0] match_q;
  logic [NSLOT-1:0] cap_q;
  logic [NCH-1:0]   pwm1_q;
  logic [NCH-1:0]   pwm2_q;
  logic [NCH-1:0]   phase_q;
  logic [2*NCH-1:0] kind_q;

  // Slot wires
  logic [NSLOT-1:0]    cap_fire;
  logic [NSLOT-1:0]    sw_we;
  logic [NSLOT-1:0]    mem_we;
  logic [NSLOT*CW-1:0] mem_wdata;
  logic [NSLOT*CW-1:0] greg_all;
  logic [CW-1:0]       mem_rd;

  function automatic logic addr_hit(input logic [5:0] w);
    addr_hit = (w < IDX_START) || (w == IDX_START) ||
               (w == IDX_CLKSEL) || (w == IDX_PINSTAT) ||
               (w[5:4] == IDX_GREG[5:4]);
  endfunction

  // Write channel decode
  wire       wr_fire   = aw_have_q & w_have_q & ~bvalid_q;
  wire       wr_hit    = addr_hit(wr_word_q);
  wire       wr_greg   = wr_word_q[5:4] == IDX_GREG[5:4];
  wire [3:0] wr_slot   = wr_word_q[3:0];
  wire       wr_lo     = wr_fire & wstrb_q[0];
  wire       aw_take   = s_axi_awvalid & s_axi_awready;
  wire       w_take    = s_axi_wvalid & s_axi_wready;

  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      wr_word_q <= '0;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      wr_word_q <= s_axi_awaddr[7:2];
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // I/O control registers
  for (genvar i = 0; i < NIO; i++) begin : g_io
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        io_q[i] <= IOCTL_RST;
      end else if (wr_lo && wr_word_q == IDX_IOAB + 6'(i)) begin
        io_q[i] <= wdata_q[7:0];
      end
    end
  end

  // Channel mode registers and their decode
  for (genvar c = 0; c < NCH; c++) begin : g_mode
    wire [5:0] mode_wr = {
      HAS_CD[c] ? wdata_q[MODE_BUFB_BIT:MODE_BUFA_BIT] : 2'b00,
      wdata_q[MODE_RSVD_BIT],
      PHASE_OK[c] & wdata_q[MODE_PHASE_BIT],
      wdata_q[1:0]};
    wire [3:0] md = mode_q[c][3:0];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mode_q[c] <= MODE_RST;
      end else if (wr_lo && wr_word_q == IDX_MODE + 6'(c)) begin
        mode_q[c] <= mode_wr;
      end
    end

    // Any code outside the listed ones is normal operation
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pwm1_q[c]          <= 1'b0;
        pwm2_q[c]          <= 1'b0;
        phase_q[c]         <= 1'b0;
        kind_q[2*c +: 2]   <= 2'b00;
      end else begin
        pwm1_q[c]          <= md == MD_PWM1;
        pwm2_q[c]          <= md == MD_PWM2;
        phase_q[c]         <= md[3:2] == MD_PHASE;
        kind_q[2*c +: 2]   <= md[1:0];
      end
    end

    assign buffer_a[c] = mode_q[c][MODE_BUFA_BIT];
    assign buffer_b[c] = mode_q[c][MODE_BUFB_BIT];
  end

  assign mode_pwm1  = pwm1_q;
  assign mode_pwm2  = pwm2_q;
  assign mode_phase = phase_q;
  assign phase_kind = kind_q;

  // Start and channel 1 clock select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_q  <= START_RST;
      clksel_q <= CLKSEL_RST;
    end else if (wr_lo && wr_word_q == IDX_START) begin
      start_q  <= wdata_q[NCH-1:0];
    end else if (wr_lo && wr_word_q == IDX_CLKSEL) begin
      clksel_q <= wdata_q[2:0];
    end
  end

  assign counter_start    = start_q;
  assign ch1_clock_select = clksel_q;

  // Per general register: compare, capture and pin
  wire ch1_src_ok = ch1_count_evt & (clksel_q != CLKSEL_UNDIV);

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    localparam int CH  = SLOT_CHAN[s];
    localparam int IOR = SLOT_IOREG[s];

    wire [3:0] ctl = SLOT_HI[s] ? io_q[IOR][7:4] : io_q[IOR][3:0];
    wire buffered = SLOT_CD[s] & (SLOT_HI[s] ?
                    mode_q[CH][MODE_BUFB_BIT] :
                    mode_q[CH][MODE_BUFA_BIT]);
    wire is_cap   = ctl[CTL_MODE_BIT] & ~buffered;
    wire is_cmp   = ~ctl[CTL_MODE_BIT] & ~buffered;
    wire drives   = is_cmp & (ctl[1:0] != OUT_DISABLED);
    wire [CW-1:0] cnt = cnt_value[CH*CW +: CW];
    wire eq       = cnt == greg_all[s*CW +: CW];
    wire match    = is_cmp & start_q[CH] & eq & ~eq_q[s];
    wire rise     = cap_pin_in[s] & ~pin_in_q[s];
    wire fall     = ~cap_pin_in[s] & pin_in_q[s];
    wire edge_hit = ctl[1] ? (rise | fall) :
                    (ctl[1:0] == CAP_FALL) ? fall : rise;
    wire use_ch1  = (s == SLOT_CH1_SRC) & ctl[CTL_SRC_BIT];
    wire src_hit  = use_ch1 ? ch1_src_ok : edge_hit;

    assign cap_fire[s] = is_cap & src_hit;
    assign sw_we[s]    = wr_fire & wr_greg & (wr_slot == 4'(s)) &
                         (wstrb_q[1:0] == 2'b11);
    // Capture outranks a software write in the same cycle
    assign mem_we[s]   = cap_fire[s] | sw_we[s];
    assign mem_wdata[s*CW +: CW] = cap_fire[s] ? cnt : wdata_q[CW-1:0];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pin_q[s] <= 1'b0;
      end else if (!start_q[CH]) begin
        pin_q[s] <= ctl[CTL_INIT_BIT];
      end else if (pwm2_q[CH] && cnt_clear[CH] && is_cmp) begin
        pin_q[s] <= ctl[CTL_INIT_BIT];
      end else if (match) begin
        case (ctl[1:0])
          OUT_LOW:    pin_q[s] <= 1'b0;
          OUT_HIGH:   pin_q[s] <= 1'b1;
          OUT_TOGGLE: pin_q[s] <= ~pin_q[s];
          default:    pin_q[s] <= pin_q[s];
        endcase
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        oe_n_q[s]   <= 1'b1;
        eq_q[s]     <= 1'b0;
        pin_in_q[s] <= 1'b0;
        match_q[s]  <= 1'b0;
        cap_q[s]    <= 1'b0;
      end else begin
        oe_n_q[s]   <= ~drives;
        eq_q[s]     <= eq;
        pin_in_q[s] <= cap_pin_in[s];
        match_q[s]  <= match;
        cap_q[s]    <= cap_fire[s];
      end
    end
  end

  assign pin_out     = pin_q;
  assign pin_oe_n    = oe_n_q;
  assign cmp_match   = match_q;
  assign capture_evt = cap_q;

  tmioc_greg_mem #(
    .N (NSLOT),
    .W (CW)
  ) u_greg (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (mem_we),
    .wdata   (mem_wdata),
    .rd_addr (s_axi_araddr[5:2]),
    .rd_q    (mem_rd),
    .all_q   (greg_all)
  );

  // Read channel: address stage, then data from registers or store
  wire        ar_take  = s_axi_arvalid & s_axi_arready;
  wire [5:0]  rw       = rd_word_q;
  wire        rd_io    = rw < IDX_MODE;
  wire        rd_mode  = (rw >= IDX_MODE) && (rw < IDX_START);
  wire        rd_greg  = rw[5:4] == IDX_GREG[5:4];
  wire [7:0]  mode_rd  = MODE_RD_ONES | {2'b00, mode_q[rw[2:0]]};
  wire [31:0] rd_val   =
    rd_io               ? {24'h000000, io_q[rw[2:0]]} :
    rd_mode             ? {24'h000000, mode_rd} :
    rw == IDX_START     ? {26'h0000000, start_q} :
    rw == IDX_CLKSEL    ? {29'h00000000, clksel_q} :
    rw == IDX_PINSTAT   ? {16'h0000, pin_q} :
    rd_greg             ? {16'h0000, mem_rd} : 32'h00000000;

  assign s_axi_arready = ~rd_stage_q & ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_stage_q <= 1'b0;
      rd_word_q  <= '0;
    end else begin
      rd_stage_q <= ar_take;
      if (ar_take) begin
        rd_word_q <= s_axi_araddr[7:2];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_stage_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= addr_hit(rw) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// >>> dv/tmioc_checker.sv
/*
  Port checker for tmioc_top.
  Assumes the bench holds bready and rready high and binds this checker.
*/
module tmioc_checker
  import tmioc_pkg::*;
(
  // Clock, reset and bus
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  // Timer side
  input wire logic [NCH-1:0]   counter_start,
  input wire logic [2:0]       ch1_clock_select,
  input wire logic [NCH-1:0]   mode_pwm1,
  input wire logic [NCH-1:0]   mode_pwm2,
  input wire logic [NCH-1:0]   mode_phase,
  input wire logic [NCH-1:0]   buffer_a,
  input wire logic [NCH-1:0]   buffer_b,
  input wire logic [NSLOT-1:0] cap_pin_in,
  input wire logic [NSLOT-1:0] pin_out,
  input wire logic [NSLOT-1:0] pin_oe_n,
  input wire logic [NSLOT-1:0] cmp_match,
  input wire logic [NSLOT-1:0] capture_evt
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence both_buf;
    (buffer_a[0] && buffer_b[0]) [*3];
  endsequence
  sequence undiv_still;
    (ch1_clock_select == CLKSEL_UNDIV && $stable(cap_pin_in[1])) [*4];
  endsequence
  sequence stopped_quiet;
    (!counter_start[0] && !s_axi_wvalid) [*4];
  endsequence

  chk_mode_excl: assert property (
    ((mode_pwm1 & mode_pwm2) | ((mode_pwm1 | mode_pwm2) & mode_phase)) == '0)
    else $error("two modes on one channel");
  chk_phase_chan: assert property (
    (mode_phase & ~PHASE_OK) == '0) else $error("phase mode on ch0 or ch3");
  chk_buf_chan: assert property (
    ((buffer_a | buffer_b) & ~HAS_CD) == '0) else $error("buffer bit set");
  chk_buf_quiet: assert property (
    both_buf |-> capture_evt[3:2] == 2'h0 && cmp_match[3:2] == 2'h0
      && pin_oe_n[3:2] == 2'h3) else $error("buffered register active");
  chk_stop_match: assert property (
    !$past(counter_start[0]) && !$past(counter_start[0], 2) |-> !cmp_match[0])
    else $error("match while stopped");
  chk_stop_level: assert property (
    stopped_quiet |-> $stable(pin_out[0])) else $error("stopped pin moved");
  chk_cap_cause: assert property (
    capture_evt[4] |-> $past(cap_pin_in[4]) != $past(cap_pin_in[4], 2)
      || $past(cap_pin_in[4], 2) != $past(cap_pin_in[4], 3))
    else $error("capture without pin edge");
  chk_ch1_undiv: assert property (
    undiv_still |-> !capture_evt[1]) else $error("undivided ch1 capture");
  chk_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("no read response");
endmodule

// >>> dv/tmioc_far.sv
/*
  Far side of the timer: channel counters, channel 1 count event, pins.
  Assumes counter_start from the block; counters hold while stopped.
*/
module tmioc_far
  import tmioc_pkg::*;
#(
  parameter int TOP = 15
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Control from block and bench
  input  wire logic [NCH-1:0]    counter_start,
  input  wire logic              slow,
  input  wire logic [NSLOT-1:0]  pin_drive,
  // Towards the block
  output logic      [NCH*CW-1:0] cnt_value,
  output logic      [NCH-1:0]    cnt_clear,
  output logic                   ch1_count_evt,
  output logic      [NSLOT-1:0]  cap_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] div_q;
  logic       tick;

  // Slow mode counts every fourth cycle
  assign tick = !slow || div_q == 2'h3;
  assign cap_pin_in = pin_drive;
  assign ch1_count_evt = tick && counter_start[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      cnt_value <= '0;
      cnt_clear <= '0;
    end else begin
      div_q <= div_q + 2'h1;
      for (int c = 0; c < NCH; c++) begin
        cnt_clear[c] <= 1'b0;
        if (tick && counter_start[c]) begin
          if (cnt_value[c*CW +: CW] == CW'(TOP)) begin
            cnt_value[c*CW +: CW] <= '0;
            cnt_clear[c] <= 1'b1;
          end else begin
            cnt_value[c*CW +: CW] <= cnt_value[c*CW +: CW] + 1'b1;
          end
        end
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
/*
  Bench for tmioc_top: AXI4-Lite tasks and register-driven scenarios.
  Assumes the far-side model drives counters and pins.
*/
module tb_top
  import tmioc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk, rst_n, slow, ch1_count_evt;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot, ch1_clock_select;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic [NCH*CW-1:0] cnt_value;
  logic [NCH-1:0]    cnt_clear, counter_start, mode_pwm1, mode_pwm2;
  logic [NCH-1:0]    mode_phase, buffer_a, buffer_b;
  logic [2*NCH-1:0]  phase_kind;
  logic [NSLOT-1:0]  cap_pin_in, pin_out, pin_oe_n, cmp_match;
  logic [NSLOT-1:0]  capture_evt, pin_drive, watch;
  logic [15:0]       hold;
  int                fail_count, n_checks, base;
  int                n_evt = 0;

  tmioc_top uut (.*);
  tmioc_far #(.TOP(15)) u_far (.*);

  always #2 mclk = ~mclk;
  always @(posedge mclk) if (|((capture_evt | cmp_match) & watch)) n_evt++;

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    close_out();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 64);
    rsp = s_axi_bresp;
    if (n >= 64) timeout();
  endtask
  task automatic bus_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 64);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n >= 64) timeout();
  endtask
  task automatic wait_match();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cmp_match[0] !== 1'b1 && n < 200);
    if (n >= 200) timeout();
  endtask

  initial begin
    mclk = 0; rst_n = 0; slow = 0; s_axi_awvalid = 0; s_axi_wvalid = 0;
    s_axi_arvalid = 0; s_axi_bready = 1; s_axi_rready = 1; s_axi_awaddr = 0;
    s_axi_araddr = 0; s_axi_awprot = 0; s_axi_arprot = 0; s_axi_wdata = 0;
    s_axi_wstrb = 4'hf; pin_drive = 0; watch = 0; fail_count = 0;
    n_checks = 0;
    tick(12);
    rst_n <= 1'b1;
    tick(1);
    for (int i = 0; i < NIO; i++) begin
      bus_rd(8'(4 * i));
      check(rd, 32'(IOCTL_RST));
      bus_wr(8'(4 * i), 32'h5a + i);
      bus_rd(8'(4 * i));
      check(rd, 32'h5a + i);
      bus_wr(8'(4 * i), 32'h0);
    end
    bus_rd(8'h44);
    check({rd[29:0], rsp}, 32'(RESP_SLVERR));
    bus_wr(8'h44, 32'h1);
    check(32'(rsp), 32'(RESP_SLVERR));
    for (int v = 0; v < 8; v++) begin
      bus_wr(8'h24, 32'(v));
      tick(2);
      check({mode_pwm1[1], mode_pwm2[1], mode_phase[1]},
            {v == 2, v == 3, v[3:2] == 2'h1});
      check(32'(phase_kind[3:2]), 32'(v[1:0]));
    end
    bus_wr(8'h24, 32'h30);
    bus_rd(8'h24);
    check(rd, 32'hc0);
    bus_wr(8'h20, 32'h04);
    bus_rd(8'h20);
    check(rd, 32'hc0);
    bus_wr(8'h20, 32'h0);
    bus_wr(8'h80, 32'h5);
    for (int k = 0; k < 4; k++) begin
      bus_wr(8'h00, 32'(k == 1 ? 5 : k));
      slow <= k[0];
      tick(2);
      check(32'(pin_out[0]), 32'(k == 1));
      check(32'(pin_oe_n[0]), 32'(k == 0));
      bus_wr(8'h38, 32'h1);
      wait_match();
      tick(1);
      if (k != 0) check(32'(pin_out[0]), 32'(k != 1));
      bus_wr(8'h38, 32'h0);
    end
    bus_wr(8'h38, 32'h2);
    tick(5);
    bus_wr(8'h38, 32'h0);
    hold = cnt_value[31:16];
    watch <= 16'h0010;
    for (int k = 0; k < 3; k++) begin
      bus_wr(8'h04, 32'(8 + k));
      base = n_evt;
      pin_drive[4] <= 1'b1;
      tick(4);
      check(32'(n_evt - base), 32'(k != 1));
      pin_drive[4] <= 1'b0;
      tick(4);
      check(32'(n_evt - base), 32'(k != 1) + 32'(k != 0));
    end
    bus_rd(8'h90);
    check(rd, {16'h0, hold});
    bus_wr(8'h00, 32'hc0);
    watch <= 16'h0002;
    bus_wr(8'h38, 32'h2);
    check(32'(counter_start), 32'h2);
    base = n_evt;
    tick(8);
    check(32'(n_evt - base), 32'h0);
    bus_wr(8'h3c, 32'h1);
    check(32'(ch1_clock_select), 32'h1);
    base = n_evt;
    tick(8);
    check(32'(n_evt > base), 32'h1);
    bus_wr(8'h38, 32'h0);
    bus_wr(8'h3c, 32'h0);
    bus_wr(8'h20, 32'h30);
    check(32'({buffer_b[0], buffer_a[0]}), 32'h3);
    bus_wr(8'h18, 32'h33);
    bus_wr(8'h88, 32'h5);
    bus_wr(8'h8c, 32'h5);
    watch <= 16'h000c;
    slow <= 1'b0;
    bus_wr(8'h38, 32'h1);
    base = n_evt;
    tick(40);
    check(32'(n_evt - base), 32'h0);
    check(32'(pin_oe_n[3:2]), 32'h3);
    bus_wr(8'h38, 32'h0);
    // PWM mode 2: toggle at match, initial level back on clear
    bus_wr(8'h20, 32'h03);
    bus_wr(8'h00, 32'h07);
    bus_wr(8'h38, 32'h1);
    check(32'(pin_out[0]), 32'h1);
    wait_match();
    tick(1);
    check(32'(pin_out[0]), 32'h0);
    tick(12);
    check(32'(pin_out[0]), 32'h1);
    bus_wr(8'h38, 32'h0);
    close_out();
  end
endmodule

bind tmioc_top tmioc_checker u_chk (.*);
